// ===== verilog/pkh_pkg.sv
/*
 * Constants of the packet handler settings block.
 * Assumes the crystal reference is the only clock.
 */
package pkh_pkg;

    // ******
    // register addresses
    // ******
    localparam logic [4:0] ADDR_SYNC_SETTINGS      = 5'h12;
    localparam logic [4:0] ADDR_SYNC_BYTE_MSB      = 5'h16;
    localparam logic [4:0] ADDR_SYNC_BYTE_SECOND   = 5'h17;
    localparam logic [4:0] ADDR_SYNC_BYTE_THIRD    = 5'h18;
    localparam logic [4:0] ADDR_SYNC_BYTE_LSB      = 5'h19;
    localparam logic [4:0] ADDR_TX_FILTER_POWER    = 5'h1A;
    localparam logic [4:0] ADDR_CLOCK_OUTPUT_CTRL  = 5'h1B;
    localparam logic [4:0] ADDR_CODING_PAYLOAD_LEN = 5'h1C;
    localparam logic [4:0] ADDR_LOCAL_NODE_ADDRESS = 5'h1D;
    localparam logic [4:0] ADDR_PACKET_FORMAT_CFG  = 5'h1E;
    localparam logic [4:0] ADDR_FIFO_CRC_CONTROL   = 5'h1F;

    // ******
    // reset values
    // ******
    localparam logic [7:0] RST_SYNC_SETTINGS   = 8'h18;
    localparam logic [7:0] RST_SYNC_BYTE       = 8'h00;
    localparam logic [7:0] RST_TX_FILTER_POWER = 8'h72;
    localparam logic [7:0] RST_CLOCK_OUTPUT    = 8'hBC;
    localparam logic [7:0] RST_CODING_LEN      = 8'h00;
    localparam logic [7:0] RST_NODE_ADDRESS    = 8'h00;
    localparam logic [7:0] RST_PACKET_FORMAT   = 8'h48;
    localparam logic [7:0] RST_FIFO_CRC        = 8'h00;

    // ******
    // field positions
    // ******
    localparam int SYNC_ON_BIT      = 5;
    localparam int SYNC_SIZE_HI     = 4;
    localparam int SYNC_SIZE_LO     = 3;
    localparam int SYNC_TOL_HI      = 2;
    localparam int SYNC_TOL_LO      = 1;
    localparam int CUTOFF_HI        = 7;
    localparam int CUTOFF_LO        = 4;
    localparam int POWER_HI         = 3;
    localparam int POWER_LO         = 1;
    localparam int CLKOUT_ON_BIT    = 7;
    localparam int CLKOUT_DIV_HI    = 6;
    localparam int CLKOUT_DIV_LO    = 2;
    localparam int MANCHESTER_BIT   = 7;
    localparam int PAYLOAD_LEN_HI   = 6;
    localparam int PAYLOAD_LEN_LO   = 0;
    localparam int PKT_FORMAT_BIT   = 7;
    localparam int PREAMBLE_HI      = 6;
    localparam int PREAMBLE_LO      = 5;
    localparam int WHITENING_BIT    = 4;
    localparam int CRC_ON_BIT       = 3;
    localparam int ADDR_FILT_HI     = 2;
    localparam int ADDR_FILT_LO     = 1;
    localparam int CRC_STATUS_BIT   = 0;
    localparam int AUTOCLR_OFF_BIT  = 7;
    localparam int STBY_READ_BIT    = 6;

    // ******
    // address filter modes and special addresses
    // ******
    localparam logic [1:0] FILT_OFF       = 2'h0;
    localparam logic [1:0] FILT_NODE      = 2'h1;
    localparam logic [1:0] FILT_NODE_ZERO = 2'h2;
    localparam logic [7:0] BCAST_ZERO     = 8'h00;
    localparam logic [7:0] BCAST_ONES     = 8'hFF;

    // ******
    // serial configuration frame: 8 header bits then 8 data bits
    // ******
    localparam logic [4:0] FRAME_HDR_LAST  = 5'h07;
    localparam logic [4:0] FRAME_DATA_LAST = 5'h0F;
    localparam int         HDR_RW_BIT      = 6;
    localparam int         HDR_ADDR_HI     = 5;
    localparam int         HDR_ADDR_LO     = 1;

endpackage

// ===== verilog/pkh_sync_match.sv
/*
 * Sync word matcher over the last 8 to 32 received bits.
 * Assumes bits arrive as one-cycle strobes on ref_clk.
 */
`timescale 1ns/100ps

module pkh_sync_match (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // configuration
    input  wire logic        enable,
    input  wire logic [1:0]  size_code,
    input  wire logic [1:0]  tolerance,
    input  wire logic [31:0] pattern,
    // bit stream
    input  wire logic        bit_valid,
    input  wire logic        bit_in,
    // result
    output logic             found
);
    import pkh_pkg::*;

    typedef struct packed {
        logic [31:0] shreg;
        logic [5:0]  fill;
        logic        found;
    } pkh_match_s;

    pkh_match_s state;
    pkh_match_s next_state;

    always_comb begin
        logic [31:0] shifted;
        logic [31:0] expected;
        logic [31:0] mask;
        logic [5:0]  need;
        logic [5:0]  errors;
        shifted  = {state.shreg[30:0], bit_in};
        expected = 32'h0;
        mask     = 32'h0;
        need     = 6'h0;
        errors   = 6'h0;
        next_state = state;
        next_state.found = 1'b0;
        // the pattern is MSB first, so a short word uses its top bytes
        unique case (size_code)
            2'b00: begin
                expected = {24'h0, pattern[31:24]};
                mask     = 32'h0000_00FF;
                need     = 6'h08;
            end
            2'b01: begin
                expected = {16'h0, pattern[31:16]};
                mask     = 32'h0000_FFFF;
                need     = 6'h10;
            end
            2'b10: begin
                expected = {8'h0, pattern[31:8]};
                mask     = 32'h00FF_FFFF;
                need     = 6'h18;
            end
            2'b11: begin
                expected = pattern;
                mask     = 32'hFFFF_FFFF;
                need     = 6'h20;
            end
        endcase
        for (int i = 0; i < 32; i++) begin
            errors = errors + {5'h0, (shifted[i] ^ expected[i]) & mask[i]};
        end
        if (!enable) begin
            next_state.fill = 6'h0;
        end else if (bit_valid) begin
            next_state.shreg = shifted;
            if (state.fill != 6'h3F) begin
                next_state.fill = state.fill + 6'h1;
            end
            if (state.fill >= need - 6'h1 && errors <= {4'h0, tolerance}) begin
                next_state.found = 1'b1;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign found = state.found;

endmodule // pkh_sync_match

// ===== verilog/pkh_config.sv
/*
 * Packet handler settings and status registers on the serial port,
 * with the clock output divider, address and length checks, CRC
 * status and FIFO auto-clear.
 * Assumes serial clock phases of eight or more ref_clk cycles,
 * datapath strobes on ref_clk, and ref_clk being the crystal.
 */
// Overview of operation
// - sync word is four bytes at 22..25, MSB first, used by size
// - sync size field: 00=8, 01=16, 10=24, 11=32 bits, default 32
// - accept sync with up to 0..3 bit errors, default zero
// - sync recognition only when enable bit set, off after reset
// - 4-bit tx smoothing cutoff in bits 7:4 of 26, default 0111
// - 3-bit tx power step in bits 3:1 of 26, default 001
// - clock output driven only while bit 7 of 27 set, default on
// - divider 00000 gives crystal, else crystal over twice field
// - Manchester coding on when bit 7 of 28 set, default off
// - fixed format: length field is payload length for tx and rx
// - variable format: length field is max rx length, unused in tx
// - 8-bit node address at 29, reset zero, used for rx filtering
// - bit 7 of 30 clear selects fixed, set selects variable length
// - preamble length from bits 6:5 of 30, one to four bytes
// - address filter modes off, node, plus 0x00, plus 0x00 and 0xFF
// - read-only bit 0 of 30 shows CRC result, 1 means pass
// - FIFO cleared on CRC failure unless bit 7 of 31 is set
// - standby FIFO access write when bit 6 of 31 clear, else read
`timescale 1ns/100ps

module pkh_config (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       reset,
    // serial configuration port
    input  wire logic       config_sel_n,
    input  wire logic       config_sck,
    input  wire logic       config_mosi,
    output logic            config_miso,
    output logic            config_miso_oe,
    // clock output pin
    output logic            clkout,
    // sync word recognition
    input  wire logic       rx_bit_valid,
    input  wire logic       rx_bit,
    output logic            sync_found,
    // received packet checks
    input  wire logic       rx_addr_valid,
    input  wire logic [7:0] rx_addr_byte,
    output logic            addr_accept,
    output logic            addr_reject,
    input  wire logic       rx_len_valid,
    input  wire logic [7:0] rx_len_byte,
    output logic            len_accept,
    output logic            len_reject,
    // CRC result and FIFO control
    input  wire logic       crc_done,
    input  wire logic       crc_pass,
    output logic            fifo_clear,
    output logic            fifo_read_in_standby,
    // decoded settings for the datapath
    output logic            manchester_on,
    output logic            whitening_on,
    output logic            crc_on,
    output logic            variable_length,
    output logic [6:0]      rx_max_length,
    output logic            tx_length_valid,
    output logic [6:0]      tx_payload_length,
    output logic [2:0]      preamble_bytes,
    output logic [3:0]      tx_smoothing_cutoff,
    output logic [2:0]      tx_power_step
);
    import pkh_pkg::*;

    typedef struct packed {
        logic [2:0]  sel_sync;
        logic [2:0]  sck_sync;
        logic [2:0]  mosi_sync;
        logic        sel_stable;
        logic        sck_stable;
        logic [4:0]  bit_cnt;
        logic [7:0]  header;
        logic [7:0]  data;
        logic [7:0]  read_buf;
        logic        miso;
        logic [7:0]  sync_settings;
        logic [31:0] sync_word;
        logic [7:0]  transmit_settings;
        logic [7:0]  oscillator_settings;
        logic [7:0]  coding_len;
        logic [7:0]  node_address;
        logic [7:0]  format_cfg;
        logic [7:0]  fifo_cfg;
        logic [4:0]  div_cnt;
        logic        div_toggle;
        logic        addr_ok;
        logic        addr_bad;
        logic        len_ok;
        logic        len_bad;
        logic        fifo_clr;
    } pkh_config_s;

    pkh_config_s state;
    pkh_config_s next_state;

    // ******
    // register read mux
    // ******
    function automatic logic [7:0] pkh_read(input pkh_config_s s, input logic [4:0] a);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            ADDR_SYNC_SETTINGS:      v = s.sync_settings;
            ADDR_SYNC_BYTE_MSB:      v = s.sync_word[31:24];
            ADDR_SYNC_BYTE_SECOND:   v = s.sync_word[23:16];
            ADDR_SYNC_BYTE_THIRD:    v = s.sync_word[15:8];
            ADDR_SYNC_BYTE_LSB:      v = s.sync_word[7:0];
            ADDR_TX_FILTER_POWER:    v = s.transmit_settings;
            ADDR_CLOCK_OUTPUT_CTRL:  v = s.oscillator_settings;
            ADDR_CODING_PAYLOAD_LEN: v = s.coding_len;
            ADDR_LOCAL_NODE_ADDRESS: v = s.node_address;
            ADDR_PACKET_FORMAT_CFG:  v = s.format_cfg;
            ADDR_FIFO_CRC_CONTROL:   v = s.fifo_cfg;
            default:                 v = 8'h00;
        endcase
        return v;
    endfunction

    // ******
    // address filter decision
    // ******
    function automatic logic pkh_addr_pass(input logic [1:0] mode, input logic [7:0] node,
                                           input logic [7:0] rx);
        logic ok;
        ok = 1'b0;
        unique case (mode)
            FILT_OFF:       ok = 1'b1;
            FILT_NODE:      ok = (rx == node);
            FILT_NODE_ZERO: ok = (rx == node) || (rx == BCAST_ZERO);
            default:        ok = (rx == node) || (rx == BCAST_ZERO) || (rx == BCAST_ONES);
        endcase
        return ok;
    endfunction

    logic sck_rise;
    logic sck_fall;
    logic selected;
    logic sel_change;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic [4:0] clk_div;

    always_comb begin
        // select and clock inputs count once the second and third stages agree
        sck_rise   = (state.sck_sync[1] == state.sck_sync[2]) && state.sck_sync[2] && !state.sck_stable;
        sck_fall   = (state.sck_sync[1] == state.sck_sync[2]) && !state.sck_sync[2] && state.sck_stable;
        sel_change = (state.sel_sync[1] == state.sel_sync[2]);
        selected   = !state.sel_stable;
        wr_addr    = state.header[HDR_ADDR_HI:HDR_ADDR_LO];
        wr_data    = {state.data[6:0], state.mosi_sync[2]};
        clk_div    = state.oscillator_settings[CLKOUT_DIV_HI:CLKOUT_DIV_LO];

        next_state = state;
        next_state.sel_sync  = {state.sel_sync[1:0], config_sel_n};
        next_state.sck_sync  = {state.sck_sync[1:0], config_sck};
        next_state.mosi_sync = {state.mosi_sync[1:0], config_mosi};
        if (sel_change) begin
            next_state.sel_stable = state.sel_sync[2];
        end
        if (sck_rise || sck_fall) begin
            next_state.sck_stable = state.sck_sync[2];
        end

        // ******
        // serial frame: header byte, then one data byte
        // ******
        if (!selected) begin
            next_state.bit_cnt = 5'h00;
        end else if (sck_rise) begin
            if (state.bit_cnt <= FRAME_HDR_LAST) begin
                next_state.header = {state.header[6:0], state.mosi_sync[2]};
            end else begin
                next_state.data = wr_data;
            end
            if (state.bit_cnt == FRAME_HDR_LAST) begin
                next_state.read_buf = pkh_read(state, state.header[HDR_ADDR_HI - 1:HDR_ADDR_LO - 1]);
            end
            if (state.bit_cnt != FRAME_DATA_LAST + 5'h01) begin
                next_state.bit_cnt = state.bit_cnt + 5'h01;
            end
            // a write takes effect on the last data bit; unmapped ones are dropped
            if (state.bit_cnt == FRAME_DATA_LAST && !state.header[HDR_RW_BIT]) begin
                unique case (wr_addr)
                    ADDR_SYNC_SETTINGS:      next_state.sync_settings       = wr_data;
                    ADDR_SYNC_BYTE_MSB:      next_state.sync_word[31:24]    = wr_data;
                    ADDR_SYNC_BYTE_SECOND:   next_state.sync_word[23:16]    = wr_data;
                    ADDR_SYNC_BYTE_THIRD:    next_state.sync_word[15:8]     = wr_data;
                    ADDR_SYNC_BYTE_LSB:      next_state.sync_word[7:0]      = wr_data;
                    ADDR_TX_FILTER_POWER:    next_state.transmit_settings   = wr_data;
                    ADDR_CLOCK_OUTPUT_CTRL:  next_state.oscillator_settings = wr_data;
                    ADDR_CODING_PAYLOAD_LEN: next_state.coding_len          = wr_data;
                    ADDR_LOCAL_NODE_ADDRESS: next_state.node_address        = wr_data;
                    // status bit is kept: host writes to it have no effect
                    ADDR_PACKET_FORMAT_CFG:  next_state.format_cfg =
                                                 {wr_data[7:1], state.format_cfg[CRC_STATUS_BIT]};
                    ADDR_FIFO_CRC_CONTROL:   next_state.fifo_cfg            = wr_data;
                    default:                 ;
                endcase
            end
        end
        if (!selected) begin
            next_state.miso = 1'b0;
        end else if (sck_fall && state.bit_cnt > FRAME_HDR_LAST && state.bit_cnt <= FRAME_DATA_LAST) begin
            next_state.miso = state.read_buf[FRAME_DATA_LAST[2:0] - state.bit_cnt[2:0]];
        end

        // ******
        // clock output divider: toggle every field-value cycles
        // ******
        if (clk_div == 5'h00 || state.div_cnt >= clk_div - 5'h01) begin
            next_state.div_cnt    = 5'h00;
            next_state.div_toggle = !state.div_toggle;
        end else begin
            next_state.div_cnt = state.div_cnt + 5'h01;
        end

        // ******
        // received packet checks
        // ******
        next_state.addr_ok  = 1'b0;
        next_state.addr_bad = 1'b0;
        if (rx_addr_valid) begin
            next_state.addr_ok  = pkh_addr_pass(state.format_cfg[ADDR_FILT_HI:ADDR_FILT_LO],
                                                state.node_address, rx_addr_byte);
            next_state.addr_bad = !next_state.addr_ok;
        end
        next_state.len_ok  = 1'b0;
        next_state.len_bad = 1'b0;
        if (rx_len_valid) begin
            // fixed format needs the exact length, variable format a ceiling
            if (state.format_cfg[PKT_FORMAT_BIT]) begin
                next_state.len_ok = rx_len_byte <= {1'b0, state.coding_len[PAYLOAD_LEN_HI:PAYLOAD_LEN_LO]};
            end else begin
                next_state.len_ok = rx_len_byte == {1'b0, state.coding_len[PAYLOAD_LEN_HI:PAYLOAD_LEN_LO]};
            end
            next_state.len_bad = !next_state.len_ok;
        end

        // status update follows the host write so a fresh result is not lost
        next_state.fifo_clr = 1'b0;
        if (crc_done && state.format_cfg[CRC_ON_BIT]) begin
            next_state.format_cfg[CRC_STATUS_BIT] = crc_pass;
            next_state.fifo_clr = !crc_pass && !state.fifo_cfg[AUTOCLR_OFF_BIT];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state                     <= '0;
            state.sel_sync            <= 3'h7;
            state.sel_stable          <= 1'b1;
            state.sync_settings       <= RST_SYNC_SETTINGS;
            state.sync_word           <= {4{RST_SYNC_BYTE}};
            state.transmit_settings   <= RST_TX_FILTER_POWER;
            state.oscillator_settings <= RST_CLOCK_OUTPUT;
            state.coding_len          <= RST_CODING_LEN;
            state.node_address        <= RST_NODE_ADDRESS;
            state.format_cfg          <= RST_PACKET_FORMAT;
            state.fifo_cfg            <= RST_FIFO_CRC;
        end else begin
            state <= next_state;
        end
    end

    // ******
    // sync word recognition
    // ******
    pkh_sync_match u_sync_match (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .enable    (state.sync_settings[SYNC_ON_BIT]),
        .size_code (state.sync_settings[SYNC_SIZE_HI:SYNC_SIZE_LO]),
        .tolerance (state.sync_settings[SYNC_TOL_HI:SYNC_TOL_LO]),
        .pattern   (state.sync_word),
        .bit_valid (rx_bit_valid),
        .bit_in    (rx_bit),
        .found     (sync_found)
    );

    // ******
    // outputs
    // ******
    assign config_miso    = state.miso;
    assign config_miso_oe = !state.sel_stable && state.header[HDR_RW_BIT] && state.bit_cnt > FRAME_HDR_LAST;
    // undivided setting passes the crystal straight through
    assign clkout = state.oscillator_settings[CLKOUT_ON_BIT] &&
                    ((clk_div == 5'h00) ? ref_clk : state.div_toggle);
    assign addr_accept          = state.addr_ok;
    assign addr_reject          = state.addr_bad;
    assign len_accept           = state.len_ok;
    assign len_reject           = state.len_bad;
    assign fifo_clear           = state.fifo_clr;
    assign fifo_read_in_standby = state.fifo_cfg[STBY_READ_BIT];
    assign manchester_on        = state.coding_len[MANCHESTER_BIT];
    assign whitening_on         = state.format_cfg[WHITENING_BIT];
    assign crc_on               = state.format_cfg[CRC_ON_BIT];
    assign variable_length      = state.format_cfg[PKT_FORMAT_BIT];
    assign rx_max_length        = state.coding_len[PAYLOAD_LEN_HI:PAYLOAD_LEN_LO];
    assign tx_length_valid      = !state.format_cfg[PKT_FORMAT_BIT];
    assign tx_payload_length    = state.coding_len[PAYLOAD_LEN_HI:PAYLOAD_LEN_LO];
    assign preamble_bytes       = {1'b0, state.format_cfg[PREAMBLE_HI:PREAMBLE_LO]} + 3'h1;
    assign tx_smoothing_cutoff  = state.transmit_settings[CUTOFF_HI:CUTOFF_LO];
    assign tx_power_step        = state.transmit_settings[POWER_HI:POWER_LO];

endmodule // pkh_config

// ===== testbench/pkh_config_assertions.sv
/* port timing checker of pkh_config. assumes one clock, synchronous reset. */
`timescale 1ns/100ps
module pkh_config_chk (
    input wire logic       ref_clk, reset, rx_addr_valid, addr_accept, addr_reject, rx_len_valid,
    input wire logic       len_accept, len_reject, variable_length, tx_length_valid, crc_done,
    input wire logic       crc_pass, crc_on, fifo_clear, sync_found, rx_bit_valid, config_sel_n, config_miso_oe,
    input wire logic [7:0] rx_len_byte,
    input wire logic [6:0] rx_max_length, tx_payload_length,
    input wire logic [2:0] preamble_bytes
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);
    sequence s_addr_ans; ##1 (addr_accept != addr_reject); endsequence
    property p_addr; rx_addr_valid |-> s_addr_ans; endproperty
    property p_apls; (addr_accept || addr_reject) |-> $past(rx_addr_valid); endproperty
    property p_vlen; variable_length && rx_len_valid
        |=> len_accept == ($past(rx_len_byte) <= {1'b0, $past(rx_max_length)}); endproperty
    property p_flen; !variable_length && rx_len_valid
        |=> len_accept == ($past(rx_len_byte) == {1'b0, $past(tx_payload_length)}); endproperty
    property p_lpls; len_accept |-> !len_reject && $past(rx_len_valid); endproperty
    property p_fmt; tx_length_valid == !variable_length; endproperty
    property p_pre; preamble_bytes inside {[1:4]}; endproperty
    property p_sync; sync_found |-> $past(rx_bit_valid); endproperty
    property p_clr; fifo_clear |-> $past(crc_done && crc_on && !crc_pass); endproperty
    property p_oe; config_miso_oe |-> !$past(config_sel_n, 4); endproperty
    a_addr: assert property (p_addr) else $error("address answer missing");
    a_apls: assert property (p_apls) else $error("stray address answer");
    a_vlen: assert property (p_vlen) else $error("variable length verdict wrong");
    a_flen: assert property (p_flen) else $error("fixed length verdict wrong");
    a_lpls: assert property (p_lpls) else $error("stray length answer");
    a_fmt: assert property (p_fmt) else $error("format outputs disagree");
    a_pre: assert property (p_pre) else $error("preamble size out of range");
    a_sync: assert property (p_sync) else $error("sync pulse without bit");
    a_clr: assert property (p_clr) else $error("fifo clear without failure");
    a_oe: assert property (p_oe) else $error("miso driven after deselect");
endmodule // pkh_config_chk
bind pkh_config pkh_config_chk u_chk (.*);

// ===== testbench/pkh_host_model.sv
/* host on the serial port, mode 0 frames. assumes ref_clk at 125 MHz. */
`timescale 1ns/100ps
module pkh_host_model (
    input  wire logic ref_clk,
    input  wire logic config_miso,
    output logic      config_sel_n,
    output logic      config_sck,
    output logic      config_mosi
);
    initial {config_sel_n, config_sck, config_mosi} = 3'h4;
    // slow phases keep every edge visible through the synchroniser
    task automatic xfer(input logic rd, input logic [4:0] a, input logic [7:0] d, output logic [7:0] q);
        logic [15:0] f;
        f = {1'b0, rd, a, 1'b0, d};
        @(posedge ref_clk) config_sel_n <= 1'b0;
        for (int i = 15; i >= 0; i--) begin
            repeat (8) @(posedge ref_clk);
            config_mosi <= f[i];
            repeat (8) @(posedge ref_clk);
            if (i < 8) q[i] = config_miso;
            config_sck <= 1'b1;
            repeat (8) @(posedge ref_clk);
            config_sck <= 1'b0;
        end
        repeat (8) @(posedge ref_clk);
        config_sel_n <= 1'b1;
        config_mosi <= ~f[0];
        repeat (8) @(posedge ref_clk);
    endtask
endmodule // pkh_host_model

// ===== testbench/tb.sv
/* self-checking bench of pkh_config. assumes the host model and checker. */
`timescale 1ns/100ps
module tb;
    import pkh_pkg::*;
    logic ref_clk = 1'b0, reset = 1'b1, rx_bit_valid = 1'b0, rx_bit = 1'b0, rx_addr_valid = 1'b0;
    logic rx_len_valid = 1'b0, crc_done = 1'b0, crc_pass = 1'b0, config_sel_n, config_sck, config_mosi;
    logic config_miso, config_miso_oe, clkout, sync_found, addr_accept, addr_reject, len_accept;
    logic len_reject, fifo_clear, fifo_read_in_standby, manchester_on, whitening_on, crc_on;
    logic variable_length, tx_length_valid;
    logic [6:0] rx_max_length, tx_payload_length;
    logic [2:0] preamble_bytes, tx_power_step;
    logic [3:0] tx_smoothing_cutoff;
    logic [7:0] rx_addr_byte = 8'h00, rx_len_byte = 8'h00, q, d, nd, bt [4];
    logic [4:0] ra [12] = '{5'h12, 5'h16, 5'h17, 5'h18, 5'h19, 5'h1A, 5'h1B, 5'h1C, 5'h1D, 5'h1E, 5'h1F, 5'h05};
    logic [7:0] rv [12] = '{8'h18, 8'h00, 8'h00, 8'h00, 8'h00, 8'h72, 8'hBC, 8'h00, 8'h00, 8'h48, 8'h00, 8'h00};
    int bad_count = 0, n_tests = 0, seed = 32'h60cc;
    realtime t;
    always #4 ref_clk = ~ref_clk;
    pkh_config uut (.*);
    pkh_host_model host (.*);
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e) begin
            bad_count++;
            $display("Error %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] v); host.xfer(1'b0, a, v, q); endtask
    task automatic rd(input logic [4:0] a); host.xfer(1'b1, a, 8'h00, q); endtask
    // k picks the strobe: 0 address, 1 length, 2 crc, 3 bit
    task automatic stb(input int k, input logic [7:0] b);
        @(posedge ref_clk);
        {rx_addr_valid, rx_len_valid, crc_done, rx_bit_valid} <= 4'(8 >> k);
        {rx_addr_byte, rx_len_byte, crc_pass, rx_bit} <= {b, b, b[0], b[0]};
        @(posedge ref_clk);
        {rx_addr_valid, rx_len_valid, crc_done, rx_bit_valid} <= 4'h0;
        #1;
    endtask
    function automatic logic [7:0] exp_addr(int m, logic [7:0] b, logic [7:0] n);
        return {7'h00, m == 0 || b == n || (m > 1 && b == 8'h00) || (m == 3 && b == 8'hFF)};
    endfunction
    function automatic logic [7:0] exp_len(int f, int b, int l); return {7'h00, f ? b <= l : b == l}; endfunction
    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (90000) @(posedge ref_clk);
        bad_count++;
        complete_run;
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        reset <= 1'b0;
        repeat (8) @(posedge ref_clk);
        for (int i = 0; i < 12; i++) begin rd(ra[i]); chk(q, rv[i]); end
        for (int i = 1; i < 5; i++) begin d = 8'($random(seed)); wr(ra[i], d); rd(ra[i]); chk(q, d); end
        d = 8'($random(seed)) & 8'hFE; // reserved bit kept at zero
        wr(ADDR_TX_FILTER_POWER, d);
        chk({tx_smoothing_cutoff, tx_power_step, 1'b0}, d);
        d = 8'($random(seed));
        wr(ADDR_CODING_PAYLOAD_LEN, d);
        chk({manchester_on, tx_payload_length}, d);
        d = 8'($random(seed)) & 8'hC0;
        wr(ADDR_FIFO_CRC_CONTROL, d);
        chk({1'b0, fifo_read_in_standby, 6'h00}, d & 8'h40);
        for (int p = 0; p < 4; p++) begin
            d = (8'($random(seed)) & 8'h9E) | 8'(p << 5);
            wr(ADDR_PACKET_FORMAT_CFG, d);
            chk({variable_length, 2'(preamble_bytes - 3'd1), whitening_on, crc_on, 3'h0}, d & 8'hF8);
        end
        $display("test registers done");
        nd = {1'b0, 6'($random(seed)), 1'b1};
        wr(ADDR_LOCAL_NODE_ADDRESS, nd);
        bt = '{nd, 8'h00, 8'hFF, nd ^ 8'h02};
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_PACKET_FORMAT_CFG, 8'h48 | 8'(m << 1));
            for (int k = 0; k < 4; k++) begin stb(0, bt[k]); chk({7'h00, addr_accept}, exp_addr(m, bt[k], nd)); end
        end
        d = (8'($random(seed)) & 8'h7F) | 8'h01;
        wr(ADDR_CODING_PAYLOAD_LEN, d);
        for (int f = 0; f < 2; f++) begin
            wr(ADDR_PACKET_FORMAT_CFG, 8'h48 | 8'(f << 7));
            for (int k = -1; k < 2; k++) begin stb(1, 8'(d + k)); chk({7'h00, len_accept}, exp_len(f, d + k, d)); end
        end
        $display("test filters done");
        wr(ADDR_PACKET_FORMAT_CFG, 8'h48);
        for (int k = 0; k < 3; k++) begin
            if (k != 1) wr(ADDR_FIFO_CRC_CONTROL, 8'(k << 6));
            stb(2, 8'(k == 1));
            chk({7'h00, fifo_clear}, 8'(k == 0));
            rd(ADDR_PACKET_FORMAT_CFG);
            chk({7'h00, q[0]}, 8'(k == 1));
        end
        wr(ADDR_CLOCK_OUTPUT_CTRL, 8'h8C);
        @(posedge clkout) t = $realtime;
        @(posedge clkout) chk(8'(int'(($realtime - t) / 8.0)), 8'h06);
        wr(ADDR_CLOCK_OUTPUT_CTRL, 8'h0C);
        chk({7'h00, clkout}, 8'h00);
        d = 8'($random(seed));
        wr(ADDR_SYNC_BYTE_MSB, d);
        bt = '{8'h00, 8'h20, 8'h22, 8'h00};
        for (int s = 0; s < 3; s++) begin
            wr(ADDR_SYNC_SETTINGS, bt[s]);
            for (int i = 7; i >= 0; i--) stb(3, (d ^ (s == 2 ? 8'h08 : 8'h00)) >> i);
            chk({7'h00, sync_found}, 8'(s > 0));
        end
        $display("test crc clock sync done");
        complete_run;
    end
endmodule // tb
